// ==== hdl/cnpe_encoder.sv ====
`include "cnpe_map.svh"
module cnpe_encoder #(
  parameter int FRAME_LEN = 256,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // frame inputs
  input wire logic frame_start,
  input wire logic [31:0] resid_energy,
  input wire logic [31:0] noise_energy,
  input wire logic [1:0] mode,
  input wire logic narrowband,
  input wire logic first_inactive,
  input wire logic empty_frame,
  input wire logic prev_inactive_full,
  input wire logic [31:0] acb_mean_energy,
  input wire logic [15:0] spec_idx,
  // payload
  output cnpe_pkg::cnpe_type_e enc_type,
  output logic [34:0] payload,
  output logic [5:0] energy_idx,
  output logic payload_valid,
  // synthesis state
  output logic [31:0] smooth_energy,
  output logic memory_reset,
  // excitation stream
  output logic exc_valid,
  input wire logic exc_ready,
  output logic [15:0] exc_data
);
  import cnpe_pkg::*;
  typedef struct packed {
    cnpe_state_e st;
    logic [1:0] mode;
    logic nb;
    logic first;
    logic empty;
    logic prevfull;
    logic [31:0] res;
    logic [31:0] noise;
    logic [31:0] acb;
    logic [15:0] spec;
    logic [31:0] es;
    logic signed [15:0] lg;
    logic signed [15:0] off;
    logic [5:0] idx;
    logic [31:0] esq;
    logic [31:0] sm;
    logic sm_init;
    logic [15:0] seed;
    logic [8:0] n;
    logic [47:0] sum;
    logic [15:0] gain;
    cnpe_type_e typ;
    logic [34:0] pay;
    logic pv;
    logic mrst;
  } cnpe_s;
  cnpe_s q, d;
  logic fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic exc_valid_q;
  logic [15:0] exc_data_q;
  logic push;
  logic [63:0] prod;
  logic [31:0] ebase;
  logic [5:0] log_int;
  logic signed [15:0] lo_lim, off_new, logv;
  logic signed [31:0] qv;
  logic [4:0] s3;
  logic [15:0] rnd;
  integer i;

  assign lo_lim = q.nb ? `CNPE_OFF_MIN_NB : `CNPE_OFF_MIN_WB;
  assign push = (q.st == CNPE_NORM) && fifo_in_ready;

  always_comb begin
    d = q;
    d.pv = 1'b0;
    d.mrst = 1'b0;
    prod = '0;
    ebase = '0;
    log_int = '0;
    off_new = '0;
    logv = '0;
    qv = '0;
    s3 = '0;
    rnd = '0;
    case (q.st)
      CNPE_IDLE: begin
        if (frame_start) begin
          d.mode = mode;
          d.nb = narrowband;
          d.first = first_inactive;
          d.empty = empty_frame;
          d.prevfull = prev_inactive_full;
          d.res = resid_energy;
          d.noise = noise_energy;
          d.acb = acb_mean_energy;
          d.spec = spec_idx;
          d.st = CNPE_LOG;
        end
      end
      CNPE_LOG: begin
        prod = 64'(q.res) * 64'(`CNPE_ES_SCALE);
        ebase = prod[47:16];
        if (q.first && q.noise < `CNPE_LOWNOISE) begin
          ebase = 32'(({32'h0, ebase} * 64'h1999) >> 16);
        end
        d.es = ebase;
        // coarse log2: integer part plus linear mantissa, q8.8
        for (i = 0; i < 32; i++) begin
          if (ebase[i]) log_int = 6'(i);
        end
        logv = 16'(({10'h0, log_int} - 16'd16) <<< 8);
        logv = logv + 16'((ebase << (6'd31 - log_int)) >> 23) - 16'sh0100;
        if (q.nb) logv = logv + `CNPE_NB_ADD;
        if (q.first) begin
          off_new = 16'((32'(`CNPE_OFF_SLOPE) * 32'(q.noise[23:8])) >>> 8)
            - `CNPE_OFF_BIAS;
        end else begin
          off_new = 16'((32'(q.off) * 32'sd230 + 32'(lo_lim) * 32'sd26) >>> 8);
        end
        if (off_new < lo_lim) off_new = lo_lim;
        if (off_new > 16'sh0000) off_new = 16'sh0000;
        d.off = off_new;
        d.lg = logv + off_new;
        d.st = CNPE_QUANT;
      end
      CNPE_QUANT: begin
        qv = (32'(q.lg) + 32'(`CNPE_LOG_BIAS)) * 32'(`CNPE_Q_MUL);
        if (qv < 0) d.idx = '0;
        else if (qv[31:16] > 16'(`CNPE_IDX_MAX6)) d.idx = `CNPE_IDX_MAX6;
        else d.idx = qv[21:16];
        qv = 32'(d.idx) * 32'(`CNPE_Q_STEP) - 32'(`CNPE_LOG_BIAS);
        d.esq = 32'h0001_0000;
        if (qv >= 0) d.esq = 32'h0001_0000 << qv[12:8];
        else d.esq = 32'h0001_0000 >> 5'(-qv[12:8]);
        if (!q.sm_init) d.sm = d.esq;
        else if (q.mode == `CNPE_MODE_IOP && q.empty) begin
          if (q.prevfull) d.sm = 32'((64'(q.acb) * 64'd51 + 64'(q.sm) * 64'd205) >> 8);
          else d.sm = q.sm;
        end else if (q.first) d.sm = 32'((64'(q.sm) + 64'(d.esq)) >> 1);
        else d.sm = 32'((64'(q.sm) * 64'd179 + 64'(d.esq) * 64'd77) >> 8);
        d.sm_init = 1'b1;
        d.n = '0;
        d.sum = '0;
        d.st = CNPE_SYNTH;
      end
      CNPE_SYNTH: begin
        // pass one: energy of the frame's random integers
        rnd = 16'(q.seed * `CNPE_SEED_MUL + `CNPE_SEED_ADD);
        d.seed = rnd;
        d.sum = q.sum + 48'($signed(rnd) * $signed(rnd));
        d.n = q.n + 9'h1;
        if (q.n == 9'(FRAME_LEN - 1)) begin
          // the replay register walks the same sequence, so the seed runs on unbroken
          d.st = CNPE_NORM;
          d.n = '0;
          // gain = integer part of sm plus one; sum is not used, accepts coarse precision
          d.gain = 16'(q.sm[31:16] + 16'h1);
        end
      end
      CNPE_NORM: begin
        if (push) begin
          d.n = q.n + 9'h1;
          if (q.n == 9'(FRAME_LEN - 1)) d.st = CNPE_OUT;
        end
      end
      default: begin
        if (q.mode == `CNPE_MODE_IOP) begin
          d.typ = CNPE_QUARTER;
          d.pay = {q.spec, 12'h0, q.idx, 1'b0};
          d.mrst = 1'b1;
        end else begin
          d.typ = CNPE_EIGHTH;
          s3 = 5'(q.spec[3:0]);
          if (q.spec[13:9] == `CNPE_IDX_ONES5 && q.spec[8:4] == `CNPE_IDX_ONES5
              && s3 == 5'hf) s3 = 5'he;
          if (q.spec[13:9] == 5'h0 && q.spec[8:4] == 5'h0 && s3 < 5'h2) s3 = 5'h2;
          d.pay = {15'h0, q.spec[13:4], s3[3:0], q.idx};
        end
        d.pv = 1'b1;
        d.st = CNPE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.seed <= `CNPE_SEED_INIT;
    end else begin
      q <= d;
    end
  end

  // scaled excitation: random word times gain, replayed from held seed
  logic [15:0] rep_seed_q;
  always_ff @(posedge clk) begin
    if (srst) rep_seed_q <= `CNPE_SEED_INIT;
    else if (push) rep_seed_q <= 16'(rep_seed_q * `CNPE_SEED_MUL + `CNPE_SEED_ADD);
  end

  cnpe_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(q.st == CNPE_NORM),
    .in_ready(fifo_in_ready),
    .in_data(16'((32'($signed(16'(rep_seed_q * `CNPE_SEED_MUL + `CNPE_SEED_ADD)))
      * 32'(q.gain)) >>> 8)),
    .out_valid(fifo_out_valid),
    .out_ready(!exc_valid_q || exc_ready),
    .out_data(fifo_out_data)
  );
  always_ff @(posedge clk) begin
    if (srst) begin
      exc_valid_q <= 1'b0;
      exc_data_q <= '0;
    end else if (!exc_valid_q || exc_ready) begin
      exc_valid_q <= fifo_out_valid;
      exc_data_q <= fifo_out_data;
    end
  end

  assign enc_type = q.typ;
  assign payload = q.pay;
  assign energy_idx = q.idx;
  assign payload_valid = q.pv;
  assign smooth_energy = q.sm;
  assign memory_reset = q.mrst;
  assign exc_valid = exc_valid_q;
  assign exc_data = exc_data_q;
endmodule // cnpe_encoder

// ==== hdl/cnpe_map.svh ====
`ifndef CNPE_MAP_SVH
`define CNPE_MAP_SVH
// fixed point: log values q8.8 signed, energies q16.16 unsigned
`define CNPE_SEED_INIT 16'h5555
`define CNPE_SEED_MUL 16'h7c4d
`define CNPE_SEED_ADD 16'h3619
`define CNPE_ES_SCALE 32'h0000_0185
`define CNPE_LOWNOISE 32'h0010_0000
`define CNPE_NB_ADD 16'sh0080
`define CNPE_OFF_MIN_NB 16'shfd00
`define CNPE_OFF_MIN_WB 16'shfdcc
`define CNPE_OFF_SLOPE 16'sh001c
`define CNPE_OFF_BIAS 16'sh03db
`define CNPE_LOG_BIAS 16'sh0200
`define CNPE_Q_MUL 16'sh02a0
`define CNPE_Q_STEP 16'sh0062
`define CNPE_MODE_IOP 2'h3
`define CNPE_IDX_ONES5 5'h1f
`define CNPE_IDX_MAX6 6'h3f
`define CNPE_FRAME_LEN 9'h100
`define CNPE_FRAME_MS 20
`endif

// ==== hdl/cnpe_pkg.sv ====
package cnpe_pkg;
  typedef enum logic [1:0] {
    CNPE_EIGHTH = 2'b00,
    CNPE_QUARTER = 2'b01
  } cnpe_type_e;
  typedef enum logic [2:0] {
    CNPE_IDLE = 3'b000,
    CNPE_LOG = 3'b001,
    CNPE_QUANT = 3'b010,
    CNPE_SYNTH = 3'b011,
    CNPE_NORM = 3'b100,
    CNPE_OUT = 3'b101
  } cnpe_state_e;
endpackage

// ==== hdl/cnpe_fifo.sv ====
module cnpe_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cnpe_fifo_s;
  cnpe_fifo_s q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    d = q;
    if (push) d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    if (pop) d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (srst) q <= '0;
    else q <= d;
    if (push) mem[q.wp] <= in_data;
  end
endmodule // cnpe_fifo

// ==== dv/cnpe_encoder_properties.sv ====
module cnpe_encoder_properties
  import cnpe_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // frame and payload
  input wire logic [1:0] mode,
  input wire cnpe_type_e enc_type,
  input wire logic [34:0] payload,
  input wire logic [5:0] energy_idx,
  input wire logic payload_valid,
  input wire logic memory_reset,
  // excitation stream
  input wire logic exc_valid,
  input wire logic exc_ready,
  input wire logic [15:0] exc_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_type_by_mode: assert property (
    payload_valid |-> enc_type == (mode == 2'h3 ? CNPE_QUARTER : CNPE_EIGHTH))
    else $error("coding type does not follow mode");
  a_qr_last_zero: assert property (
    payload_valid && enc_type == CNPE_QUARTER |-> !payload[0] && payload[6:1] == energy_idx)
    else $error("quarter payload tail wrong");
  a_er_layout: assert property (
    payload_valid && enc_type == CNPE_EIGHTH |-> payload[34:20] == 15'h0
      && payload[5:0] == energy_idx)
    else $error("eighth payload layout wrong");
  a_er_no_ones: assert property (
    payload_valid && enc_type == CNPE_EIGHTH |-> payload[19:6] != 14'h3fff)
    else $error("all ones eighth indices");
  a_er_no_zero: assert property (
    payload_valid && enc_type == CNPE_EIGHTH && payload[19:10] == 10'h0 |-> payload[9:6] > 4'h1)
    else $error("forbidden third index after zero pair");
  a_mem_reset_iop: assert property (
    memory_reset |-> payload_valid && enc_type == CNPE_QUARTER)
    else $error("memory reset outside interop payload");
  a_pv_pulse: assert property (
    $rose(payload_valid) |=> !payload_valid [*8])
    else $error("payload valid not a single pulse");
  a_stream_hold: assert property (
    exc_valid && !exc_ready |=> exc_valid && $stable(exc_data))
    else $error("excitation word dropped while stalled");
  c_eighth: cover property (payload_valid && enc_type == CNPE_EIGHTH);
  c_quarter: cover property (payload_valid && memory_reset);
  c_stall: cover property ((exc_valid && !exc_ready) [*4]);
endmodule // cnpe_encoder_properties

bind cnpe_encoder cnpe_encoder_properties u_cnpe_encoder_properties (.clk(clk), .srst(srst),
  .mode(mode), .enc_type(enc_type), .payload(payload), .energy_idx(energy_idx),
  .payload_valid(payload_valid), .memory_reset(memory_reset), .exc_valid(exc_valid),
  .exc_ready(exc_ready), .exc_data(exc_data));

// ==== dv/cnpe_sink.sv ====
module cnpe_sink (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // stream
  input wire logic hold,
  input wire logic exc_valid,
  output logic exc_ready,
  output logic [15:0] words
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_q;
  // slow packer: one stall in four, none taken at all while held
  assign exc_ready = !hold && ph_q != 2'h0;
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_q <= 2'h0;
      words <= 16'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (exc_valid && exc_ready) words <= words + 16'h1;
    end
  end
endmodule // cnpe_sink

// ==== dv/comfort_noise_param_encoder_tb_top.sv ====
module comfort_noise_param_encoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cnpe_pkg::*;
  logic clk, srst, frame_start, narrowband, first_inactive, hold, payload_valid;
  logic memory_reset, exc_valid, exc_ready;
  logic [31:0] resid_energy, noise_energy, smooth_energy;
  logic [1:0] mode;
  logic [15:0] spec_idx, exc_data, words;
  logic [34:0] payload, p_s;
  logic [5:0] energy_idx;
  cnpe_type_e enc_type;
  int failures, n_checks;
  cnpe_encoder u_cnpe_encoder (.clk(clk), .srst(srst), .frame_start(frame_start),
    .resid_energy(resid_energy), .noise_energy(noise_energy), .mode(mode),
    .narrowband(narrowband), .first_inactive(first_inactive), .empty_frame(1'b0),
    .prev_inactive_full(1'b0), .acb_mean_energy(32'h0001_0000), .spec_idx(spec_idx),
    .enc_type(enc_type), .payload(payload), .energy_idx(energy_idx),
    .payload_valid(payload_valid), .smooth_energy(smooth_energy),
    .memory_reset(memory_reset), .exc_valid(exc_valid), .exc_ready(exc_ready),
    .exc_data(exc_data));
  cnpe_sink u_cnpe_sink (.clk(clk), .srst(srst), .hold(hold), .exc_valid(exc_valid),
    .exc_ready(exc_ready), .words(words));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one frame, inputs held until the next; 40 cycles let the fifo drain
  task automatic frame(input logic [1:0] md, input logic nb, input logic fi,
                       input logic [31:0] ne, input logic [15:0] sp);
    int k;
    logic [15:0] w0;
    w0 = words;
    mode = md;
    narrowband = nb;
    first_inactive = fi;
    noise_energy = ne;
    spec_idx = sp;
    frame_start = 1;
    @(posedge clk);
    #1 frame_start = 0;
    k = 0;
    while (payload_valid !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    chk("frame done", k < 3000, 1);
    p_s = payload;
    chk("type", enc_type, md == 2'h3 ? CNPE_QUARTER : CNPE_EIGHTH);
    chk("memory reset", memory_reset, md == 2'h3);
    repeat (40) @(posedge clk);
    #1 chk("words", words - w0, 16'd256);
  endtask
  task automatic t_modes();
    frame(2'h0, 0, 1, 32'h0040_0000, 16'hb3c5);
    chk("first smoothed energy", smooth_energy, 32'h0040_0000);
    for (int m = 1; m < 4; m++) frame(m[1:0], 0, 1, 32'h0040_0000, 16'hb3c5);
    chk("first frames smoothing", smooth_energy, 32'h0040_0000);
    chk("quarter spec", p_s[34:19], 16'hb3c5);
    chk("quarter tail", p_s[0], 0);
  endtask
  task automatic t_split();
    logic [15:0] sp [3] = '{16'h1559, 16'h3fff, 16'h0000};
    logic [3:0] i3 [3] = '{4'h9, 4'he, 4'h2};
    for (int i = 0; i < 3; i++) begin
      frame(2'h1, 0, 0, 32'h0040_0000, sp[i]);
      chk("split pair", p_s[19:10], sp[i][13:4]);
      chk("third index", p_s[9:6], i3[i]);
    end
  endtask
  // per-sample energy near 73 keeps every index far from a level edge
  task automatic t_energy();
    frame(2'h0, 0, 1, 32'h0040_0000, 16'h1559);
    chk("wide first", energy_idx, 6'd21);
    frame(2'h2, 0, 0, 32'h0040_0000, 16'h1559);
    chk("wide later", energy_idx, 6'd20);
    frame(2'h0, 1, 1, 32'h0040_0000, 16'h1559);
    chk("narrow clamp", energy_idx, 6'd22);
    frame(2'h0, 1, 1, 32'h0008_0000, 16'h1559);
    chk("quiet first", energy_idx, 6'd6);
  endtask
  // packer holds off long enough for the fifo to fill and refuse
  task automatic t_stall();
    fork
      frame(2'h3, 0, 0, 32'h0040_0000, 16'h0f0f);
      begin
        hold = 1;
        repeat (400) @(posedge clk);
        #1 hold = 0;
      end
    join
  endtask
  initial begin
    srst = 1;
    frame_start = 0;
    hold = 0;
    mode = 2'h0;
    narrowband = 0;
    first_inactive = 0;
    resid_energy = 32'h3012_0000;
    noise_energy = 32'h0;
    spec_idx = 16'h0;
    repeat (3) @(posedge clk);
    #1 srst = 0;
    chk("idle payload valid", payload_valid, 0);
    chk("idle smoothed energy", smooth_energy, 0);
    t_modes();
    t_split();
    t_energy();
    t_stall();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("BAD watchdog expected done seen hang");
    close_out();
  end
endmodule // comfort_noise_param_encoder_tb_top
